/* common/pci_seq_defs.svh */
// Constants of the PCI master read/write sequencer
// ============================================================================
`ifndef PCI_SEQ_DEFS_SVH
`define PCI_SEQ_DEFS_SVH
`define PSQ_FIFO_DEPTH 8
`define PSQ_FIFO_WIDTH 66
`define PSQ_CMD_WRITE_BIT 0
`define PSQ_IO_CMD_HI 3'h1
`define PSQ_CFG_CMD_HI 3'h5
`endif

/* common/pci_seq_pkg.sv */
// Types of the PCI master read/write sequencer
package pci_seq_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_REQ   = 6'h02,
    ST_ADACK = 6'h04,
    ST_ADDR  = 6'h08,
    ST_DATA  = 6'h10,
    ST_TURN  = 6'h20
  } seq_state_t;
endpackage : pci_seq_pkg

/* dv/pci_bus_partner.sv */
// Arbiter and target model on the PCI side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module pci_bus_partner (
  // Clock, reset and test controls
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        wide_tgt_i,
  input  wire logic        stall_i,
  // Master drivers
  input  wire logic        req_n_i,
  input  wire logic        frame_n_i,
  input  wire logic        frame_oe_i,
  input  wire logic        irdy_n_i,
  input  wire logic        irdy_oe_i,
  input  wire logic        req64_n_i,
  input  wire logic        req64_oe_i,
  // Bus as seen by the master
  output logic             gnt_n_o,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             devsel_n_o,
  output logic             trdy_n_o,
  output logic             ack64_n_o,
  output logic [63:0]      ad_o
);
  logic [31:0] cnt_q;
  logic        fr_q;
  logic        req64_n;
  logic        done;
  // Pulled-up control lines float high when released
  assign frame_n_o = frame_oe_i ? frame_n_i : 1'b1;
  assign irdy_n_o  = irdy_oe_i ? irdy_n_i : 1'b1;
  assign req64_n   = req64_oe_i ? req64_n_i : 1'b1;
  assign done      = !irdy_n_o && !trdy_n_o;
  // Stale data is inverted so it never passes for a fresh word
  assign ad_o = {~cnt_q, trdy_n_o ? ~cnt_q : cnt_q};
  always_ff @(posedge ref_clk_i) begin
    fr_q    <= frame_n_o;
    gnt_n_o <= srst_i | req_n_i;
    if (srst_i || (done && frame_n_o)) begin
      devsel_n_o <= 1'b1;
      trdy_n_o   <= 1'b1;
      ack64_n_o  <= 1'b1;
      cnt_q      <= 32'h0;
    end else if (fr_q && !frame_n_o) begin
      devsel_n_o <= 1'b0;
      ack64_n_o  <= !wide_tgt_i || req64_n;
    end else if (!devsel_n_o) begin
      trdy_n_o <= stall_i;
      cnt_q    <= cnt_q + 32'(done);
    end
  end
endmodule : pci_bus_partner
`default_nettype wire

/* dv/pci_master_seq_asserts.sv */
// Port-level assertions for the PCI master sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pci_seq_defs.svh"
module pci_master_seq_asserts (
  // Watched ports of the sequencer
  input wire logic        ref_clk_i,
  input wire logic        srst_i,
  input wire logic        local_narrow_request_n_i,
  input wire logic        local_wide_request_n_i,
  input wire logic        local_final_word_n_i,
  input wire logic [63:0] local_adr_i,
  input wire logic [3:0]  local_cmd_i,
  input wire logic [7:0]  local_byte_en_n_i,
  input wire logic        local_master_ready_n_i,
  input wire logic        address_accepted_n_o,
  input wire logic        pci_req_n_o,
  input wire logic        pci_gnt_n_i,
  input wire logic        pci_frame_n_i,
  input wire logic        pci_irdy_n_i,
  input wire logic        pci_frame_n_o,
  input wire logic        pci_frame_oe_o,
  input wire logic        pci_irdy_n_o,
  input wire logic        pci_irdy_oe_o,
  input wire logic        pci_req64_n_o,
  input wire logic        pci_req64_oe_o,
  input wire logic [63:0] pci_ad_o,
  input wire logic        pci_ad_oe_o,
  input wire logic [7:0]  pci_cbe_n_o,
  input wire logic        pci_cbe_oe_o
);
  logic io_cfg;
  logic single_q;
  logic single_d;
  // I/O and configuration commands never widen
  assign io_cfg = local_cmd_i[3:1] == `PSQ_IO_CMD_HI ||
                  local_cmd_i[3:1] == `PSQ_CFG_CMD_HI;
  // Final flag frozen once FRAME# is driven, so late flags are not singles;
  // reads only, as a mismatched single write still moves two dwords
  always_comb single_d = pci_frame_oe_o ? single_q :
    !local_final_word_n_i && !local_cmd_i[`PSQ_CMD_WRITE_BIT];
  always_ff @(posedge ref_clk_i) single_q <= !srst_i && single_d;
  // ==========
  // Properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_addr_phase;
    !pci_frame_n_o && pci_frame_oe_o ##1 pci_irdy_oe_o;
  endsequence
  a_req_on_request: assert property (
    $fell(pci_req_n_o) |-> !$past(local_narrow_request_n_i) ||
    !$past(local_wide_request_n_i)) else $error("bus request unasked");
  a_grant_idle: assert property (
    $fell(address_accepted_n_o) |-> !$past(pci_gnt_n_i) &&
    $past(pci_frame_n_i) && $past(pci_irdy_n_i))
    else $error("address taken without grant on idle bus");
  a_frame_start: assert property (
    $fell(address_accepted_n_o) |=> s_addr_phase)
    else $error("frame or irdy driver late");
  a_addr_cmd: assert property (
    $fell(pci_frame_n_o) |-> pci_ad_o[31:0] == $past(local_adr_i[31:0]) &&
    pci_cbe_n_o[3:0] == $past(local_cmd_i))
    else $error("address phase carries wrong address or command");
  a_drivers_on: assert property (
    $fell(pci_frame_n_o) |->
    pci_req64_oe_o && pci_ad_oe_o && pci_cbe_oe_o)
    else $error("address phase drivers not enabled");
  a_byte_enables: assert property (
    $rose(pci_irdy_oe_o) |-> pci_cbe_n_o == $past(local_byte_en_n_i))
    else $error("byte enables not passed on");
  a_wide_start: assert property (
    $fell(pci_frame_n_o) |->
    pci_req64_n_o == ($past(local_wide_request_n_i) || io_cfg))
    else $error("wide request line wrong at address phase");
  a_ready_stop: assert property (
    local_master_ready_n_i |=> pci_irdy_n_o)
    else $error("irdy kept low with local side not ready");
  a_single_frame: assert property (
    !pci_irdy_n_o && pci_irdy_oe_o && single_q |-> pci_frame_n_o)
    else $error("single transfer keeps frame low");
endmodule : pci_master_seq_asserts
bind pci_master_seq pci_master_seq_asserts chk (
  .ref_clk_i, .srst_i, .local_narrow_request_n_i, .local_wide_request_n_i,
  .local_final_word_n_i, .local_adr_i, .local_cmd_i, .local_byte_en_n_i,
  .local_master_ready_n_i, .address_accepted_n_o, .pci_req_n_o,
  .pci_gnt_n_i, .pci_frame_n_i, .pci_irdy_n_i, .pci_frame_n_o,
  .pci_frame_oe_o, .pci_irdy_n_o, .pci_irdy_oe_o, .pci_req64_n_o,
  .pci_req64_oe_o, .pci_ad_o, .pci_ad_oe_o, .pci_cbe_n_o, .pci_cbe_oe_o
);
`default_nettype wire

/* dv/test_pci_master_read_write_sequencer.sv */
// Self-checking bench for the PCI master sequencer
`timescale 1ns/1ps
`default_nettype none
module test_pci_master_read_write_sequencer;
  logic        ref_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        nreq_n = 1'b1;
  logic        wreq_n = 1'b1;
  logic        last_n = 1'b1;
  logic        rdy_n = 1'b1;
  logic        wide_tgt = 1'b1;
  logic        stall = 1'b0;
  logic [3:0]  cmd = 4'h6;
  logic [7:0]  be_n = 8'hFF;
  logic [63:0] adr = 64'h0;
  logic [63:0] wdat = 64'h0;
  int          seed = 66696;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [3:0]  cmds [8] = '{4'h6, 4'h7, 4'h2, 4'h3, 4'hA, 4'hB, 4'hF, 4'hC};
  logic        adr_ack_n, ack_n, xfr_n, lo_ack_n, hi_ack_n, req_n, gnt_n;
  logic        frame_n, frame_o, frame_oe, irdy_n, irdy_o, irdy_oe, ad_oe;
  logic        req64_o, req64_oe, ack64_n, devsel_n, trdy_n, cbe_oe;
  logic [7:0]  cbe;
  logic [63:0] rdat, ad_o, ad_i;
  pci_master_seq dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .local_narrow_request_n_i(nreq_n), .local_wide_request_n_i(wreq_n),
    .local_final_word_n_i(last_n), .local_adr_i(adr), .local_cmd_i(cmd),
    .local_byte_en_n_i(be_n), .address_accepted_n_o(adr_ack_n),
    .local_master_ready_n_i(rdy_n), .local_wdat_i(wdat),
    .local_master_acknowledge_n_o(ack_n), .local_transfer_strobe_n_o(xfr_n),
    .low_dword_ack_n_o(lo_ack_n), .high_dword_ack_n_o(hi_ack_n),
    .local_rdat_o(rdat), .pci_req_n_o(req_n), .pci_gnt_n_i(gnt_n),
    .pci_frame_n_i(frame_n), .pci_frame_n_o(frame_o),
    .pci_frame_oe_o(frame_oe), .pci_irdy_n_i(irdy_n), .pci_irdy_n_o(irdy_o),
    .pci_irdy_oe_o(irdy_oe), .pci_req64_n_o(req64_o),
    .pci_req64_oe_o(req64_oe), .pci_ack64_n_i(ack64_n),
    .pci_devsel_n_i(devsel_n), .pci_trdy_n_i(trdy_n), .pci_ad_i(ad_i),
    .pci_ad_o(ad_o), .pci_ad_oe_o(ad_oe), .pci_cbe_n_o(cbe),
    .pci_cbe_oe_o(cbe_oe)
  );
  pci_bus_partner bus (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wide_tgt_i(wide_tgt),
    .stall_i(stall), .req_n_i(req_n), .frame_n_i(frame_o),
    .frame_oe_i(frame_oe), .irdy_n_i(irdy_o), .irdy_oe_i(irdy_oe),
    .req64_n_i(req64_o), .req64_oe_i(req64_oe), .gnt_n_o(gnt_n),
    .frame_n_o(frame_n), .irdy_n_o(irdy_n), .devsel_n_o(devsel_n),
    .trdy_n_o(trdy_n), .ack64_n_o(ack64_n), .ad_o(ad_i)
  );
  always #10 ref_clk_i = ~ref_clk_i;
  // ==========
  // Helpers
  function automatic logic [63:0] exp_word(input logic [31:0] k);
    return {~k, k};
  endfunction : exp_word
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // One transaction; fin is the delay of the final flag after acceptance
  task automatic xact(input logic [3:0] c, input logic w, input logic wt,
                      input int fin);
    int   j;
    int   m;
    int   n;
    int   idle;
    logic go;
    logic rd;
    logic mis;
    logic full;
    j = 0;
    m = 0;
    n = 0;
    idle = 0;
    go = 1'b0;
    rd = !c[0];
    mis = w && !wt && c[3:1] != 3'h1 && c[3:1] != 3'h5;
    full = w && wt && c[3:1] != 3'h1 && c[3:1] != 3'h5;
    @(posedge ref_clk_i);
    cmd <= c;
    adr <= {$random(seed), $random(seed)} & ~64'h7;
    wdat <= {$random(seed), $random(seed)};
    be_n <= 8'($random(seed));
    wide_tgt <= wt;
    nreq_n <= 1'b0;
    wreq_n <= !w;
    last_n <= fin != 0;
    while (idle < 3) begin
      @(negedge ref_clk_i);
      n++;
      go = go || !adr_ack_n;
      idle = (go && !frame_oe && !irdy_oe && ack_n && xfr_n) ? idle + 1 : 0;
      if (rd && !xfr_n) begin
        chk(full ? rdat : 64'(rdat[31:0]), full ? exp_word(j) : 64'(j));
        if (mis) chk(64'({lo_ack_n, hi_ack_n}), 64'({j[0], ~j[0]}));
        j++;
      end
      if (!rd && !irdy_o && irdy_oe && !trdy_n && !devsel_n) begin
        if (full) chk(ad_o, wdat);
        else chk(64'(ad_o[31:0]), 64'(m[0] && mis ? wdat[63:32] : wdat[31:0]));
        m++;
      end
      if (!rd && !ack_n) j++;
      if (n > 400) begin
        miscompares++;
        idle = 3;
      end
      @(posedge ref_clk_i);
      if (go) begin
        nreq_n <= 1'b1;
        wreq_n <= 1'b1;
        fin--;
        if (fin <= 0) last_n <= 1'b0;
      end
      rdy_n <= ($random(seed) & 3) == 0;
      stall <= ($random(seed) & 3) == 0;
    end
    chk(64'(j > 0), 64'h1);
    repeat (2) @(posedge ref_clk_i);
    last_n <= 1'b1;
  endtask : xact
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(64'({req_n, adr_ack_n, frame_oe, irdy_oe, ad_oe}), 64'h18);
    xact(4'h6, 1'b1, 1'b1, 0);
    xact(4'h6, 1'b0, 1'b1, 0);
    xact(4'h6, 1'b1, 1'b0, 4);
    xact(4'h2, 1'b1, 1'b1, 0);
    xact(4'hA, 1'b1, 1'b1, 0);
    xact(4'h7, 1'b1, 1'b1, 3);
    xact(4'hF, 1'b0, 1'b1, 2);
    xact(4'h7, 1'b1, 1'b0, 4);
    for (int i = 0; i < 16; i++) begin
      xact(cmds[i % 8], 1'($random(seed)), 1'($random(seed)),
           2 * ($random(seed) & 3));
    end
    complete_run();
  end
endmodule : test_pci_master_read_write_sequencer
`default_nettype wire

/* src/pci_master_seq.sv */
// PCI master-mode transaction sequencer, local side to PCI bus
`timescale 1ns/1ps
`default_nettype none
`include "pci_seq_defs.svh"
module pci_master_seq
  import pci_seq_pkg::*;
#(
  parameter bit VAR_BYTE_EN = 1'b0,
  parameter int FIFO_DEPTH  = `PSQ_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // Local request and address
  input  wire logic        local_narrow_request_n_i,
  input  wire logic        local_wide_request_n_i,
  input  wire logic        local_final_word_n_i,
  input  wire logic [63:0] local_adr_i,
  input  wire logic [3:0]  local_cmd_i,
  input  wire logic [7:0]  local_byte_en_n_i,
  output logic             address_accepted_n_o,
  // Local data handshake
  input  wire logic        local_master_ready_n_i,
  input  wire logic [63:0] local_wdat_i,
  output logic             local_master_acknowledge_n_o,
  output logic             local_transfer_strobe_n_o,
  output logic             low_dword_ack_n_o,
  output logic             high_dword_ack_n_o,
  output logic [63:0]      local_rdat_o,
  // PCI arbitration
  output logic             pci_req_n_o,
  input  wire logic        pci_gnt_n_i,
  // PCI control, three signals each for FRAME# and IRDY#, two for REQ64#
  input  wire logic        pci_frame_n_i,
  output logic             pci_frame_n_o,
  output logic             pci_frame_oe_o,
  input  wire logic        pci_irdy_n_i,
  output logic             pci_irdy_n_o,
  output logic             pci_irdy_oe_o,
  output logic             pci_req64_n_o,
  output logic             pci_req64_oe_o,
  input  wire logic        pci_ack64_n_i,
  input  wire logic        pci_devsel_n_i,
  input  wire logic        pci_trdy_n_i,
  // PCI address/data and command/byte enables
  input  wire logic [63:0] pci_ad_i,
  output logic [63:0]      pci_ad_o,
  output logic             pci_ad_oe_o,
  output logic [7:0]       pci_cbe_n_o,
  output logic             pci_cbe_oe_o
);
  // ==========================================================================
  // State
  // ==========================================================================
  seq_state_t  state_q, state_d;
  logic        req_n_q, req_n_d, aack_n_q, aack_n_d;
  logic        frame_q, frame_d, frame_oe_q, frame_oe_d;
  logic        irdy_q, irdy_d, irdy_oe_q, irdy_oe_d;
  logic        r64_q, r64_d, r64_oe_q, r64_oe_d;
  logic [63:0] ad_q, ad_d;
  logic        ad_oe_q, ad_oe_d, cbe_oe_q, cbe_oe_d;
  logic [7:0]  cbe_q, cbe_d;
  logic        wide_q, wide_d, last_q, last_d;
  logic        rd_q, rd_d, half_q, half_d;
  logic        ack_n_q, ack_n_d, stb_n_q, stb_n_d;
  logic        lo_n_q, lo_n_d, hi_n_q, hi_n_d;
  logic [63:0] rdat_q, rdat_d;

  // FIFO between PCI read data and the local side
  logic                       f_in_valid, f_in_ready, f_out_valid, pop;
  logic [`PSQ_FIFO_WIDTH-1:0] f_in_data, f_out_data;

  logic xfer, go, w64, mis, final_now, word_done, io_cfg;

  // A completed PCI data phase: IRDY# and TRDY# both low, target claimed
  assign xfer = (state_q == ST_DATA) && !irdy_q && !pci_trdy_n_i
                && !pci_devsel_n_i;
  // Reads stall IRDY# while the FIFO is full so no word is ever lost
  assign go   = !local_master_ready_n_i && (!rd_q || f_in_ready);
  assign w64  = wide_q && !pci_ack64_n_i;
  assign mis  = wide_q && pci_ack64_n_i;
  // A wide local word on a narrow target needs its high half sent too
  assign word_done = !mis || half_q;
  assign final_now = (last_q || !local_final_word_n_i)
                     && (rd_q || word_done);
  assign io_cfg = (local_cmd_i[3:1] == `PSQ_IO_CMD_HI)
               || (local_cmd_i[3:1] == `PSQ_CFG_CMD_HI);

  // Mismatched reads carry one dword in bits 31..0 with a half tag
  assign f_in_valid = xfer && rd_q;
  assign f_in_data  = w64 ? {2'h3, pci_ad_i} :
                      mis ? {!half_q, half_q, 32'h0, pci_ad_i[31:0]} :
                            {2'h2, 32'h0, pci_ad_i[31:0]};
  assign pop = f_out_valid && !local_master_ready_n_i;

  word_fifo #(
    .WIDTH (`PSQ_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (!local_master_ready_n_i),
    .out_data_o  (f_out_data)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    state_d    = state_q;
    req_n_d    = req_n_q;
    aack_n_d   = 1'b1;
    frame_d    = frame_q;
    frame_oe_d = frame_oe_q;
    irdy_d     = irdy_q;
    irdy_oe_d  = irdy_oe_q;
    r64_d      = r64_q;
    r64_oe_d   = r64_oe_q;
    ad_d       = ad_q;
    ad_oe_d    = ad_oe_q;
    cbe_d      = cbe_q;
    cbe_oe_d   = cbe_oe_q;
    wide_d     = wide_q;
    last_d     = last_q;
    rd_d       = rd_q;
    half_d     = half_q;
    case (state_q)
      ST_IDLE: begin
        irdy_oe_d = 1'b0;
        half_d    = 1'b0;
        last_d    = 1'b0;
        // Old read data drains before a new transaction may start
        if (!f_out_valid && (!local_narrow_request_n_i
            || !local_wide_request_n_i)) begin
          wide_d  = !local_wide_request_n_i;
          last_d  = !local_final_word_n_i;
          req_n_d = 1'b0;
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        last_d = last_q || !local_final_word_n_i;
        if (!pci_gnt_n_i && pci_frame_n_i && pci_irdy_n_i) begin
          aack_n_d = 1'b0;
          state_d  = ST_ADACK;
        end
      end
      ST_ADACK: begin
        // Address and command are valid on the local inputs now
        last_d     = last_q || !local_final_word_n_i;
        rd_d       = !local_cmd_i[`PSQ_CMD_WRITE_BIT];
        wide_d     = wide_q && !io_cfg;
        ad_d       = local_adr_i;
        ad_oe_d    = 1'b1;
        cbe_d      = {local_cmd_i, local_cmd_i};
        cbe_oe_d   = 1'b1;
        frame_d    = 1'b0;
        frame_oe_d = 1'b1;
        r64_d      = !(wide_q && !io_cfg);
        r64_oe_d   = 1'b1;
        irdy_d     = 1'b1;
        req_n_d    = 1'b1;
        state_d    = ST_ADDR;
      end
      ST_ADDR: begin
        last_d    = last_q || !local_final_word_n_i;
        cbe_d     = local_byte_en_n_i;
        irdy_oe_d = 1'b1;
        ad_oe_d   = !rd_q;
        // FRAME# rises only together with an IRDY# assertion, never alone
        state_d = ST_DATA;
      end
      ST_DATA: begin
        if (!local_final_word_n_i) begin
          last_d = 1'b1;
        end
        if (xfer && !rd_q && mis) begin
          half_d = !half_q;
        end else if (xfer && mis) begin
          half_d = !half_q;
        end
        if (xfer && frame_q) begin
          // Final phase done: drive IRDY# high one cycle, then release; FRAME#, REQ64#, AD and C/BE# release at once
          irdy_d     = 1'b1;
          frame_oe_d = 1'b0;
          r64_d      = 1'b1;
          r64_oe_d   = 1'b0;
          ad_oe_d    = 1'b0;
          cbe_oe_d   = 1'b0;
          state_d    = ST_TURN;
        end else begin
          irdy_d = !go;
          if (go && final_now) begin
            frame_d = 1'b1;
            r64_d   = 1'b1;
          end
          if (go && !rd_q) begin
            ad_d = w64 ? local_wdat_i :
                   (mis && (half_q ^ xfer)) ?
                   {32'h0, local_wdat_i[63:32]} :
                   {32'h0, local_wdat_i[31:0]};
          end
          if (go && VAR_BYTE_EN) begin
            cbe_d = local_byte_en_n_i;
          end
        end
      end
      ST_TURN: begin
        irdy_oe_d = 1'b0;
        frame_d   = 1'b1;
        state_d   = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Local answer side
  // ==========================================================================
  always_comb begin
    rdat_d  = rdat_q;
    ack_n_d = 1'b1;
    stb_n_d = 1'b1;
    lo_n_d  = lo_n_q;
    hi_n_d  = hi_n_q;
    if (rd_q) begin
      // Acknowledge follows FIFO content: a TRDY# wait empties it
      ack_n_d = !f_out_valid;
      stb_n_d = !pop;
      if (pop) begin
        rdat_d = f_out_data[63:0];
        lo_n_d = !f_out_data[65];
        hi_n_d = !f_out_data[64];
      end
    end else if (xfer && word_done) begin
      ack_n_d = 1'b0;
      stb_n_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q    <= ST_IDLE;
      req_n_q    <= 1'b1;
      aack_n_q   <= 1'b1;
      frame_q    <= 1'b1;
      frame_oe_q <= 1'b0;
      irdy_q     <= 1'b1;
      irdy_oe_q  <= 1'b0;
      r64_q      <= 1'b1;
      r64_oe_q   <= 1'b0;
      ad_q       <= 64'h0;
      ad_oe_q    <= 1'b0;
      cbe_q      <= 8'hFF;
      cbe_oe_q   <= 1'b0;
      wide_q     <= 1'b0;
      last_q     <= 1'b0;
      rd_q       <= 1'b0;
      half_q     <= 1'b0;
      ack_n_q    <= 1'b1;
      stb_n_q    <= 1'b1;
      lo_n_q     <= 1'b1;
      hi_n_q     <= 1'b1;
      rdat_q     <= 64'h0;
    end else begin
      state_q    <= state_d;
      req_n_q    <= req_n_d;
      aack_n_q   <= aack_n_d;
      frame_q    <= frame_d;
      frame_oe_q <= frame_oe_d;
      irdy_q     <= irdy_d;
      irdy_oe_q  <= irdy_oe_d;
      r64_q      <= r64_d;
      r64_oe_q   <= r64_oe_d;
      ad_q       <= ad_d;
      ad_oe_q    <= ad_oe_d;
      cbe_q      <= cbe_d;
      cbe_oe_q   <= cbe_oe_d;
      wide_q     <= wide_d;
      last_q     <= last_d;
      rd_q       <= rd_d;
      half_q     <= half_d;
      ack_n_q    <= ack_n_d;
      stb_n_q    <= stb_n_d;
      lo_n_q     <= lo_n_d;
      hi_n_q     <= hi_n_d;
      rdat_q     <= rdat_d;
    end
  end

  assign address_accepted_n_o         = aack_n_q;
  assign local_master_acknowledge_n_o = ack_n_q;
  assign local_transfer_strobe_n_o    = stb_n_q;
  assign low_dword_ack_n_o            = lo_n_q;
  assign high_dword_ack_n_o           = hi_n_q;
  assign local_rdat_o                 = rdat_q;
  assign pci_req_n_o                  = req_n_q;
  assign pci_frame_n_o                = frame_q;
  assign pci_frame_oe_o               = frame_oe_q;
  assign pci_irdy_n_o                 = irdy_q;
  assign pci_irdy_oe_o                = irdy_oe_q;
  assign pci_req64_n_o                = r64_q;
  assign pci_req64_oe_o               = r64_oe_q;
  assign pci_ad_o                     = ad_q;
  assign pci_ad_oe_o                  = ad_oe_q;
  assign pci_cbe_n_o                  = cbe_q;
  assign pci_cbe_oe_o                 = cbe_oe_q;
endmodule : pci_master_seq
`default_nettype wire

/* src/word_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("word_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : word_fifo
`default_nettype wire
